// ==== sea_pkg.sv ====
// Operation
// - Each byte has a ten-bit word address: two bits from addressing byte, eight following.
// - Byte write: acknowledge addressing byte, word address byte, then the data byte.
// - Write ends with stop; stop starts the self-timed programming cycle.
// - While programming, bus inputs are ignored; reads and writes are not processed.
// - One programming cycle writes one to 16 bytes of the same row.
// - Page write: up to fifteen further data bytes, each acknowledged.
// - After each write byte only the low four address bits increment, wrapping in page.
// - Acknowledge polling: addressing byte is not acknowledged until programming ends.
// - Protect pin high guards the whole array; low leaves it writable.
// - Protect pin is sampled at the stop; later changes do not abort programming.
// - Protected write still acknowledges all bytes, skips programming, stays ready.
// - Address counter holds last address plus one, kept between operations, wraps to zero.
// - Read with no word address sends the byte at the address counter.
// - Controller not-acknowledge after a read byte ends the read; device goes to standby.
// - High address bits in a read addressing byte are ignored.
// - Each acknowledged read byte advances the address; wraps from top to start.
// - Every array byte starts as all ones.
// - Addressing byte: type in bits 7:4, chip select bit 3, address 9:8, direction.
// - Type or chip select mismatch: no acknowledge, back to standby.
package sea_pkg;

   localparam int         ADDR_W          = 10;
   localparam int         MEM_BYTES       = 1024;
   localparam int         PAGE_W          = 4;
   localparam int         PAGE_BYTES      = 16;
   localparam int         BYTE_W          = 8;
   localparam int         FIFO_DEPTH      = 8;
   localparam int         FIFO_W          = PAGE_W + BYTE_W;
   localparam int         DA_RW_BIT       = 0;
   localparam int         DA_HI_LSB       = 1;
   localparam int         DA_CS_BIT       = 3;
   localparam int         DA_TYPE_LSB     = 4;
   localparam logic [7:0] ERASED_BYTE     = 8'hff;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
   localparam int         PROG_CYCLES_DEF = 1000;
   localparam int         BUSY_W          = 24;

   typedef enum logic [2:0] {
      S_IDLE,
      S_DEV,
      S_WORD,
      S_WDATA,
      S_RDATA,
      S_COMMIT,
      S_PROG
   } sea_state_t;

endpackage

// ==== sea_eeprom.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Write data FIFO
// ----------------------------------------
module sea_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_sys_i,
   input  wire logic             nrst_i,
   input  wire logic             s_valid_i,
   output logic                  s_ready_o,
   input  wire logic [WIDTH-1:0] s_data_i,
   output logic                  m_valid_o,
   input  wire logic             m_ready_i,
   output logic      [WIDTH-1:0] m_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               rd;
      logic [PW-1:0]               wr;
      logic [PW:0]                 cnt;
   } sea_fifo_st_t;

   sea_fifo_st_t q;
   sea_fifo_st_t d;
   logic         push;
   logic         pop;

   assign s_ready_o = (q.cnt != (PW+1)'(DEPTH));
   assign m_valid_o = (q.cnt != '0);
   assign m_data_o  = q.mem[q.rd];
   assign push      = s_valid_i & s_ready_o;
   assign pop       = m_valid_o & m_ready_i;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = s_data_i;
         d.wr        = (q.wr == PW'(DEPTH-1)) ? '0 : q.wr + PW'(1);
      end
      if (pop) begin
         d.rd = (q.rd == PW'(DEPTH-1)) ? '0 : q.rd + PW'(1);
      end
      if (push && !pop) begin
         d.cnt = q.cnt + (PW+1)'(1);
      end else if (pop && !push) begin
         d.cnt = q.cnt - (PW+1)'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ----------------------------------------
// Two-wire EEPROM target
// ----------------------------------------
module sea_eeprom #(
   parameter int         PROG_CYCLES = sea_pkg::PROG_CYCLES_DEF,
   parameter logic [3:0] DEV_TYPE_ID = 4'h5  // Value is arbitrary
) (
   input  wire logic clk_sys_i,
   input  wire logic nrst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_n_o,
   input  wire logic wp_i,
   input  wire logic chip_select_i,
   output logic      busy_o
);
   typedef struct packed {
      logic                                                 scl_m;
      logic                                                 scl_s;
      logic                                                 scl_p;
      logic                                                 sda_m;
      logic                                                 sda_s;
      logic                                                 sda_p;
      logic                                                 wp_m;
      logic                                                 wp_s;
      logic                                                 cs_m;
      logic                                                 cs_s;
      sea_pkg::sea_state_t                                  state;
      sea_pkg::sea_state_t                                  nxt;
      logic                                                 ackph;
      logic [3:0]                                           bitcnt;
      logic [7:0]                                           shreg;
      logic [7:0]                                           txreg;
      logic [sea_pkg::ADDR_W-1:0]                           addr;
      logic [1:0]                                           addr_hi;
      logic                                                 wr_pend;
      logic [sea_pkg::BUSY_W-1:0]                           busy_cnt;
      logic [sea_pkg::PAGE_BYTES-1:0][sea_pkg::BYTE_W-1:0]  pbuf;
      logic [sea_pkg::PAGE_BYTES-1:0]                       pval;
      logic [sea_pkg::MEM_BYTES-1:0][sea_pkg::BYTE_W-1:0]   mem;
      logic                                                 sda_o;
      logic                                                 sda_oe_n;
      logic                                                 busy;
   } sea_core_st_t;

   sea_core_st_t                  q;
   sea_core_st_t                  d;
   logic                          start_c;
   logic                          stop_c;
   logic                          rise_c;
   logic                          fall_c;
   logic                          wr_byte_c;
   logic                          fifo_in_rdy;
   logic                          fifo_out_vld;
   logic                          drain_rdy;
   logic [sea_pkg::FIFO_W-1:0]    fifo_out_data;
   logic                          dev_match;

   // ----------------------------------------
   // Bus events
   // ----------------------------------------
   assign start_c   = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
   assign stop_c    = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
   assign rise_c    = q.scl_s & ~q.scl_p;
   assign fall_c    = ~q.scl_s & q.scl_p;
   assign wr_byte_c = fall_c & ~start_c & ~stop_c & ~q.ackph
                      & (q.bitcnt == sea_pkg::BITS_PER_BYTE) & (q.state == sea_pkg::S_WDATA);
   assign drain_rdy = (q.state != sea_pkg::S_PROG);
   assign dev_match = (q.shreg[7:sea_pkg::DA_TYPE_LSB] == DEV_TYPE_ID)
                      & (q.shreg[sea_pkg::DA_CS_BIT] == q.cs_s);

   assign sda_o      = q.sda_o;
   assign sda_oe_n_o = q.sda_oe_n;
   assign busy_o     = q.busy;

   sea_fifo #(
      .WIDTH (sea_pkg::FIFO_W),
      .DEPTH (sea_pkg::FIFO_DEPTH)
   ) u_wfifo (
      .clk_sys_i (clk_sys_i),
      .nrst_i    (nrst_i),
      .s_valid_i (wr_byte_c),
      .s_ready_o (fifo_in_rdy),
      .s_data_i  ({q.addr[sea_pkg::PAGE_W-1:0], q.shreg}),
      .m_valid_o (fifo_out_vld),
      .m_ready_i (drain_rdy),
      .m_data_o  (fifo_out_data)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      d       = q;
      d.scl_m = scl_i;
      d.scl_s = q.scl_m;
      d.scl_p = q.scl_s;
      d.sda_m = sda_i;
      d.sda_s = q.sda_m;
      d.sda_p = q.sda_s;
      d.wp_m  = wp_i;
      d.wp_s  = q.wp_m;
      d.cs_m  = chip_select_i;
      d.cs_s  = q.cs_m;
      d.busy  = (q.state == sea_pkg::S_COMMIT) || (q.state == sea_pkg::S_PROG);

      // Page buffer fill from FIFO
      if (fifo_out_vld && drain_rdy) begin
         d.pbuf[fifo_out_data[sea_pkg::FIFO_W-1:sea_pkg::BYTE_W]] =
            fifo_out_data[sea_pkg::BYTE_W-1:0];
         d.pval[fifo_out_data[sea_pkg::FIFO_W-1:sea_pkg::BYTE_W]] = 1'b1;
      end

      case (q.state)
         sea_pkg::S_COMMIT: begin
            // Inputs ignored until programming is done
            if (!fifo_out_vld) begin
               for (int i = 0; i < sea_pkg::PAGE_BYTES; i++) begin
                  if (q.pval[i]) begin
                     d.mem[{q.addr[sea_pkg::ADDR_W-1:sea_pkg::PAGE_W],
                            sea_pkg::PAGE_W'(i)}] = q.pbuf[i];
                  end
               end
               d.pval     = '0;
               d.busy_cnt = sea_pkg::BUSY_W'(PROG_CYCLES - 1);
               d.state    = sea_pkg::S_PROG;
            end
         end
         sea_pkg::S_PROG: begin
            if (q.busy_cnt == '0) begin
               d.state = sea_pkg::S_IDLE;
            end else begin
               d.busy_cnt = q.busy_cnt - sea_pkg::BUSY_W'(1);
            end
         end
         default: begin
            if (start_c) begin
               d.state    = sea_pkg::S_DEV;
               d.bitcnt   = '0;
               d.ackph    = 1'b0;
               d.pval     = '0;
               d.wr_pend  = 1'b0;
               d.sda_o    = 1'b1;
               d.sda_oe_n = 1'b1;
            end else if (stop_c) begin
               d.sda_o    = 1'b1;
               d.sda_oe_n = 1'b1;
               d.ackph    = 1'b0;
               d.wr_pend  = 1'b0;
               if (q.wr_pend && !q.wp_s) begin
                  d.state = sea_pkg::S_COMMIT;
               end else begin
                  d.state = sea_pkg::S_IDLE;
                  d.pval  = '0;
               end
            end else if (q.state != sea_pkg::S_IDLE) begin
               if (rise_c) begin
                  if (!q.ackph && q.bitcnt != sea_pkg::BITS_PER_BYTE) begin
                     d.shreg  = {q.shreg[6:0], q.sda_s};
                     d.bitcnt = q.bitcnt + 4'h1;
                  end else if (q.ackph && q.state == sea_pkg::S_RDATA) begin
                     if (!q.sda_s) begin
                        d.ackph  = 1'b0;
                        d.bitcnt = '0;
                        d.txreg  = q.mem[q.addr];
                        d.addr   = q.addr + 10'h1;
                     end else begin
                        d.state = sea_pkg::S_IDLE;
                     end
                  end
               end else if (fall_c) begin
                  if (q.ackph) begin
                     if (q.state != sea_pkg::S_RDATA) begin
                        d.ackph    = 1'b0;
                        d.bitcnt   = '0;
                        d.state    = q.nxt;
                        d.sda_o    = 1'b1;
                        d.sda_oe_n = 1'b1;
                        if (q.nxt == sea_pkg::S_RDATA) begin
                           d.txreg    = {q.mem[q.addr][6:0], 1'b0};
                           d.sda_o    = q.mem[q.addr][7];
                           d.sda_oe_n = q.mem[q.addr][7];
                           d.addr     = q.addr + 10'h1;
                        end
                     end
                  end else if (q.bitcnt == sea_pkg::BITS_PER_BYTE) begin
                     d.ackph = 1'b1;
                     case (q.state)
                        sea_pkg::S_DEV: begin
                           if (dev_match) begin
                              d.sda_o    = 1'b0;
                              d.sda_oe_n = 1'b0;
                              if (q.shreg[sea_pkg::DA_RW_BIT]) begin
                                 d.nxt = sea_pkg::S_RDATA;
                              end else begin
                                 d.addr_hi = q.shreg[sea_pkg::DA_HI_LSB+1:sea_pkg::DA_HI_LSB];
                                 d.nxt     = sea_pkg::S_WORD;
                              end
                           end else begin
                              d.ackph = 1'b0;
                              d.state = sea_pkg::S_IDLE;
                           end
                        end
                        sea_pkg::S_WORD: begin
                           d.addr     = {q.addr_hi, q.shreg};
                           d.sda_o    = 1'b0;
                           d.sda_oe_n = 1'b0;
                           d.nxt      = sea_pkg::S_WDATA;
                        end
                        sea_pkg::S_WDATA: begin
                           d.nxt = sea_pkg::S_WDATA;
                           if (fifo_in_rdy) begin
                              d.sda_o    = 1'b0;
                              d.sda_oe_n = 1'b0;
                              d.wr_pend  = 1'b1;
                              d.addr[sea_pkg::PAGE_W-1:0] =
                                 q.addr[sea_pkg::PAGE_W-1:0] + 4'h1;
                           end
                        end
                        default: begin
                           d.sda_o    = 1'b1;
                           d.sda_oe_n = 1'b1;
                        end
                     endcase
                  end else if (q.state == sea_pkg::S_RDATA) begin
                     d.sda_o    = q.txreg[7];
                     d.sda_oe_n = q.txreg[7];
                     d.txreg    = {q.txreg[6:0], 1'b0};
                  end
               end
            end
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         q          <= '0;
         q.state    <= sea_pkg::S_IDLE;
         q.nxt      <= sea_pkg::S_IDLE;
         q.scl_m    <= 1'b1;
         q.scl_s    <= 1'b1;
         q.scl_p    <= 1'b1;
         q.sda_m    <= 1'b1;
         q.sda_s    <= 1'b1;
         q.sda_p    <= 1'b1;
         q.sda_o    <= 1'b1;
         q.sda_oe_n <= 1'b1;
         q.mem      <= {sea_pkg::MEM_BYTES{sea_pkg::ERASED_BYTE}};
      end else begin
         q <= d;
      end
   end
endmodule

// ==== sea_eeprom_sva.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Port checks of the EEPROM target
// ----------------------------------------
module sea_eeprom_sva #(
   parameter int PROG_CYCLES = 20
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n_o,
   input wire logic wp_i,
   input wire logic chip_select_i,
   input wire logic busy_o
);
   logic [7:0]  since_stop_q;
   logic [15:0] busy_len_q;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   sequence s_stop;
      scl_i && $rose(sda_i);
   endsequence
   sequence s_start;
      scl_i && $fell(sda_i);
   endsequence
   // Cycles since a stop on the pins, and length of the busy interval
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         since_stop_q <= 8'hff;
         busy_len_q   <= 16'h0;
      end else begin
         since_stop_q <= (scl_i && $rose(sda_i)) ? 8'h00
                         : since_stop_q + {7'h0, since_stop_q != 8'hff};
         busy_len_q   <= busy_o ? busy_len_q + 16'h1 : 16'h0;
      end
   end
   chk_oe_value: assert property (!sda_oe_n_o |-> !sda_o)
      else $error("data line driven high");
   chk_busy_quiet: assert property (busy_o |-> sda_oe_n_o)
      else $error("bus answered while busy");
   chk_busy_cause: assert property ($rose(busy_o) |-> since_stop_q <= 8'd12)
      else $error("busy began without a stop");
   chk_wp_skip: assert property (s_stop ##0 (wp_i && $past(wp_i, 6) && !busy_o)
      |-> !busy_o [*8])
      else $error("protected write started programming");
   chk_busy_max: assert property (busy_len_q <= PROG_CYCLES + 8)
      else $error("busy interval too long");
   chk_busy_min: assert property ($fell(busy_o) |-> busy_len_q >= PROG_CYCLES)
      else $error("busy interval too short");
   chk_start_quiet: assert property (s_start |-> sda_oe_n_o [*8])
      else $error("data line driven right after start");
   chk_reset_idle: assert property ($rose(nrst_i) |-> sda_oe_n_o && !busy_o)
      else $error("outputs not idle after reset");
endmodule

bind sea_eeprom sea_eeprom_sva #(.PROG_CYCLES(PROG_CYCLES)) sea_eeprom_sva_i (
   .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe_n_o(sda_oe_n_o), .wp_i(wp_i), .chip_select_i(chip_select_i), .busy_o(busy_o));

// ==== sea_ctrl_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Bus controller model, SCL idles high, 64 ns period
// ----------------------------------------
module sea_ctrl_model (
   input  wire logic clk_sys_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic hc();
      repeat (2) @(posedge clk_sys_i);
   endtask
   // Data set mid low phase, sampled at end of high phase
   task automatic bit_io(input logic b, output logic r);
      scl_o <= 1'b0;
      hc();
      sda_low_o <= !b;
      hc();
      scl_o <= 1'b1;
      hc();
      hc();
      r = sda_i;
   endtask
   task automatic start();
      scl_o <= 1'b0;
      hc();
      sda_low_o <= 1'b0;
      hc();
      scl_o <= 1'b1;
      hc();
      sda_low_o <= 1'b1;
      hc();
   endtask
   task automatic stop();
      scl_o <= 1'b0;
      hc();
      sda_low_o <= 1'b1;
      hc();
      scl_o <= 1'b1;
      hc();
      sda_low_o <= 1'b0;
      hc();
   endtask
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(!more, r);
   endtask
endmodule

// ==== sea_eeprom_tb.sv ====
`timescale 1ns/1ps
module sea_eeprom_tb;
   localparam int         PROG = 40;
   localparam logic [3:0] TYPE = 4'h5; // Value is arbitrary
   logic       clk_sys_i, nrst_i, wp_i, chip_select_i, sda_o, sda_oe_n_o, busy_o, scl, sda_low, ack;
   wire        sda = !sda_low && !(!sda_oe_n_o && !sda_o);
   int         err_count, tests_run, cyc;
   logic [7:0] mem [1024];
   logic [9:0] cnt, a;

   sea_eeprom #(.PROG_CYCLES(PROG), .DEV_TYPE_ID(TYPE)) sea_eeprom_i (.clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
      .wp_i(wp_i), .chip_select_i(chip_select_i), .busy_o(busy_o));
   sea_ctrl_model sea_ctrl_model_i (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl),
      .sda_low_o(sda_low));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      sea_ctrl_model_i.wr_byte(b, ack);
      check("ack", {7'h0, ack}, {7'h0, exp_ack});
   endtask
   task automatic wr(input logic [9:0] a0, input int n, input logic prot);
      logic [7:0] v;
      logic [9:0] p;
      p = a0;
      wp_i <= prot;
      sea_ctrl_model_i.start();
      send({TYPE, chip_select_i, p[9:8], 1'b0}, 1'b1);
      send(p[7:0], 1'b1);
      for (int i = 0; i < n; i++) begin
         v = 8'($urandom);
         send(v, 1'b1);
         if (!prot) mem[p] = v;
         p = {p[9:4], p[3:0] + 4'h1};
      end
      sea_ctrl_model_i.stop();
      cnt = p;
      repeat (4) @(posedge clk_sys_i);
      check("busy", {7'h0, busy_o}, {7'h0, !prot});
   endtask
   task automatic poll();
      for (int i = 0; i < 2; i++) begin
         sea_ctrl_model_i.start();
         send({TYPE, chip_select_i, 3'b000}, i[0]);
         sea_ctrl_model_i.stop();
      end
   endtask
   task automatic rd(input logic [9:0] a0, input int n, input logic rnd);
      logic [7:0] v;
      if (rnd) begin
         sea_ctrl_model_i.start();
         send({TYPE, chip_select_i, a0[9:8], 1'b0}, 1'b1);
         send(a0[7:0], 1'b1);
         cnt = a0;
      end
      sea_ctrl_model_i.start();
      send({TYPE, chip_select_i, 2'($urandom), 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         sea_ctrl_model_i.rd_byte(i < n - 1, v);
         check("data", v, mem[cnt]);
         cnt = cnt + 10'h1;
      end
      sea_ctrl_model_i.stop();
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #4 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc >= 60000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      nrst_i = 1'b0;
      wp_i = 1'b0;
      chip_select_i = 1'b0;
      void'($urandom(32'h2df2));
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 8'hff;
      end
      chip_select_i <= 1'($urandom);
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      rd(10'h3fe, 4, 1'b1);
      // Full page from mid-row, wraps within the row
      a = {6'($urandom), 4'ha};
      wr(a, 16, 1'b0);
      poll();
      rd(cnt, 1, 1'b0);
      rd({a[9:4], 4'h0}, 16, 1'b1);
      wr(a + 10'h20, 3, 1'b1);
      rd(a + 10'h20, 3, 1'b1);
      wr(a + 10'h40, 2, 1'b0);
      wp_i <= 1'b1;
      poll();
      wp_i <= 1'b0;
      rd(a + 10'h40, 2, 1'b1);
      sea_ctrl_model_i.start();
      send({TYPE, !chip_select_i, 3'b000}, 1'b0);
      sea_ctrl_model_i.start();
      send({TYPE ^ 4'h3, chip_select_i, 3'b001}, 1'b0);
      sea_ctrl_model_i.stop();
      give_verdict();
   end
endmodule
